// >>> tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CMP_CAP_A = 8'h18;
  localparam logic [7:0] IDX_CAP_B = 8'h19;
  localparam logic [7:0] IDX_CTRL = 8'h1A;
  localparam logic [7:0] IDX_EXT_INT_CTRL = 8'h37;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h38;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h39;
  localparam int ADDR_W = 10;

  // ==========================================================================
  // Control and external interrupt control register field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_CLK_LSB = 2;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_SOFTWARE_CAPTURE_BIT = 6;
  localparam int EDGE_SEL_BIT = 3;

  // Interrupt status bits
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================================
  // Mode and source clock encodings
  localparam logic MODE_TIMER = 1'b0;
  localparam logic MODE_CAPTURE = 1'b1;
  localparam logic [1:0] SRC_DIV4096 = 2'h0;
  localparam logic [1:0] SRC_DIV1024 = 2'h1;
  localparam logic [1:0] SRC_DIV128 = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;

  // Prescaler terminal masks for each division ratio
  localparam int PRESC_W = 12;
  localparam logic [11:0] MASK_DIV4096 = 12'hFFF;
  localparam logic [11:0] MASK_DIV1024 = 12'h3FF;
  localparam logic [11:0] MASK_DIV128 = 12'h07F;

  // Reset values and special data
  localparam logic [7:0] CAP_OVF_VALUE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0;

  // ==========================================================================
  // Control fields held by the block
  typedef struct packed {
    logic run;
    logic [1:0] src_sel;
    logic mode;
  } tcc_ctrl_s;

  // Pin edge pulses
  typedef struct packed {
    logic active;
    logic opposite;
  } tcc_edges_s;

endpackage
`default_nettype wire

// >>> tcc_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic falling_sel,
  output tcc_pkg::tcc_edges_s edges
);

  logic pin_q;
  logic primed_q;
  logic rise;
  logic fall;

  // ==========================================================================
  // Previous pin level; first sample only primes the detector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      primed_q <= 1'b0;
    end else begin
      pin_q <= pin;
      primed_q <= 1'b1;
    end
  end

  // Raw edges
  assign rise = primed_q && pin && !pin_q;
  assign fall = primed_q && !pin && pin_q;

  // Active edge per the edge select, opposite edge the other one
  assign edges = falling_sel ? {fall, rise} : {rise, fall};

endmodule
`default_nettype wire

// >>> tcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
  parameter int CNT_W = 8,
  parameter int PRESC_W = tcc_pkg::PRESC_W
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [tcc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TIMER_INPUT_PIN,
  output logic TIMER_INTERRUPT
);

  // ==========================================================================
  // Declarations
  localparam int IRQ_W_L = tcc_pkg::IRQ_W;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ALL = '1;

  // Software-visible register state
  tcc_pkg::tcc_ctrl_s ctrl_q;
  logic edge_sel_q;
  logic [IRQ_W_L-1:0] irq_status_q;
  logic [IRQ_W_L-1:0] irq_status_d;
  logic [IRQ_W_L-1:0] irq_mask_q;
  logic [CNT_W-1:0] cmp_cap_a_q;
  logic [CNT_W-1:0] cap_b_q;

  // Counting path
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_inc;
  logic [PRESC_W-1:0] presc_q;
  logic internal_tick;
  logic count_pulse;
  logic lock_q;
  tcc_pkg::tcc_edges_s pin_edges;

  // Bus read path
  logic rd_pend_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_mux;
  logic rd_done_a;

  // Address decode and write strobes
  logic sel_a;
  logic sel_b;
  logic sel_ctrl;
  logic sel_eic;
  logic sel_st;
  logic sel_mk;
  logic wr_lane;
  logic wr_a;
  logic wr_ctrl;

  // Counter events and the software capture strobe
  logic software_capture_pulse;
  logic match_ev;
  logic cap_a_ev;
  logic cap_b_ev;
  logic ovf_ev;
  logic any_ev;

  // ==========================================================================
  // Address decode: byte address is the index times four
  // Only whole words are decoded; the two lowest address bits must be zero
  assign sel_a = AVS_ADDRESS == {tcc_pkg::IDX_CMP_CAP_A, 2'b00};
  assign sel_b = AVS_ADDRESS == {tcc_pkg::IDX_CAP_B, 2'b00};
  assign sel_ctrl = AVS_ADDRESS == {tcc_pkg::IDX_CTRL, 2'b00};
  assign sel_eic = AVS_ADDRESS == {tcc_pkg::IDX_EXT_INT_CTRL, 2'b00};
  assign sel_st = AVS_ADDRESS == {tcc_pkg::IDX_IRQ_STATUS, 2'b00};
  assign sel_mk = AVS_ADDRESS == {tcc_pkg::IDX_IRQ_MASK, 2'b00};

  // Writes complete in the cycle they are presented; low lane carries data
  assign wr_lane = AVS_WRITE && AVS_BYTEENABLE[0];
  assign wr_a = wr_lane && sel_a;
  assign wr_ctrl = wr_lane && sel_ctrl;

  // Software capture request rides on a control write, never stored
  assign software_capture_pulse = wr_ctrl && AVS_WRITEDATA[tcc_pkg::CTRL_SOFTWARE_CAPTURE_BIT]
    && (ctrl_q.mode == tcc_pkg::MODE_TIMER);

  // Reads take one wait cycle; completion edge is where side effects land
  // Writes never wait
  assign AVS_WAITREQUEST = AVS_READ && !rd_pend_q;
  assign AVS_READDATA = rd_data_q;
  assign rd_done_a = AVS_READ && rd_pend_q && sel_a;

  // ==========================================================================
  // Read pending flag for the single wait state
  // High for one cycle only, so back-to-back reads each wait once
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= AVS_READ && !rd_pend_q;
    end
  end

  // Read data multiplexer; control register is write-only and reads zero
  // Unmapped words read zero as well
  always_comb begin
    rd_mux = tcc_pkg::ZERO_WORD;
    if (sel_a) begin
      rd_mux[CNT_W-1:0] = cmp_cap_a_q;
    end else if (sel_b) begin
      rd_mux[CNT_W-1:0] = cap_b_q;
    end else if (sel_eic) begin
      rd_mux[tcc_pkg::EDGE_SEL_BIT] = edge_sel_q;
    end else if (sel_st) begin
      rd_mux[IRQ_W_L-1:0] = irq_status_q;
    end else if (sel_mk) begin
      rd_mux[IRQ_W_L-1:0] = irq_mask_q;
    end
  end

  // Read data register, loaded during the wait cycle
  // Registered so the mux settles a full cycle before the answer
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rd_data_q <= tcc_pkg::ZERO_WORD;
    end else if (AVS_READ && !rd_pend_q) begin
      rd_data_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Control register; software capture bit is not held
  // All fields load together from one write
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q.mode <= AVS_WRITEDATA[tcc_pkg::CTRL_MODE_BIT];
      ctrl_q.src_sel <= AVS_WRITEDATA[tcc_pkg::CTRL_CLK_LSB +: 2];
      ctrl_q.run <= AVS_WRITEDATA[tcc_pkg::CTRL_RUN_BIT];
    end
  end

  // Edge select bit of the external interrupt control register
  // Other bits of that register read zero
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      edge_sel_q <= 1'b0;
    end else if (wr_lane && sel_eic) begin
      edge_sel_q <= AVS_WRITEDATA[tcc_pkg::EDGE_SEL_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_mask_q <= '0;
    end else if (wr_lane && sel_mk) begin
      irq_mask_q <= AVS_WRITEDATA[IRQ_W_L-1:0];
    end
  end

  // ==========================================================================
  // Free-running prescaler from the system clock
  // Not cleared by the run bit, so the first tick after start may be early
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // Internal tick at the selected division ratio
  // Pin source gives no internal tick
  always_comb begin
    case (ctrl_q.src_sel)
      tcc_pkg::SRC_DIV4096: begin
        internal_tick = (presc_q & tcc_pkg::MASK_DIV4096)
          == tcc_pkg::MASK_DIV4096;
      end
      tcc_pkg::SRC_DIV1024: begin
        internal_tick = (presc_q & tcc_pkg::MASK_DIV1024)
          == tcc_pkg::MASK_DIV1024;
      end
      tcc_pkg::SRC_DIV128: begin
        internal_tick = (presc_q & tcc_pkg::MASK_DIV128)
          == tcc_pkg::MASK_DIV128;
      end
      default: begin
        internal_tick = 1'b0;
      end
    endcase
  end

  // Pin edge detector on the timer input
  // Edge select can be changed at any time, even while the counter runs
  tcc_edge_det u_edge (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .pin(TIMER_INPUT_PIN),
    .falling_sel(edge_sel_q),
    .edges(pin_edges)
  );

  // Counting mode takes the pin's active edge when the pin is the source
  // Capture mode ignores this and counts internal ticks
  assign count_pulse = (ctrl_q.src_sel == tcc_pkg::SRC_PIN)
    ? pin_edges.active : internal_tick;

  assign cnt_inc = cnt_q + CNT_ONE;

  // ==========================================================================
  // Counter next value and events
  always_comb begin
    cnt_d = cnt_q;
    match_ev = 1'b0;
    cap_a_ev = 1'b0;
    cap_b_ev = 1'b0;
    ovf_ev = 1'b0;
    if (!ctrl_q.run) begin
      cnt_d = CNT_ZERO;
    end else if (ctrl_q.mode == tcc_pkg::MODE_TIMER) begin
      // Incremented value is compared, so N gives a period of N counts
      if (count_pulse) begin
        if (cnt_inc == cmp_cap_a_q) begin
          cnt_d = CNT_ZERO;
          match_ev = 1'b1;
        end else begin
          cnt_d = cnt_inc;
        end
      end
    end else begin
      // Capture mode free-runs on the internal clock
      // An active edge outranks an overflow tick in the same cycle
      if (internal_tick) begin
        cnt_d = cnt_inc;
      end
      if (!lock_q && pin_edges.active) begin
        cnt_d = CNT_ZERO;
        cap_a_ev = 1'b1;
      end else if (!lock_q && internal_tick && cnt_q == CNT_ALL) begin
        ovf_ev = 1'b1;
      end
      if (!lock_q && pin_edges.opposite) begin
        cap_b_ev = 1'b1;
      end
    end
  end

  assign any_ev = match_ev || cap_a_ev || ovf_ev;

  // Up-counter
  // Cleared every cycle while stopped
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Capture interlock: set by capture or overflow, cleared by reading A
  // Stopping or leaving capture mode drops a pending interlock
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      lock_q <= 1'b0;
    end else if (!ctrl_q.run || ctrl_q.mode == tcc_pkg::MODE_TIMER) begin
      lock_q <= 1'b0;
    end else if (cap_a_ev || ovf_ev) begin
      lock_q <= 1'b1;
    end else if (rd_done_a) begin
      lock_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Compare / capture A register, no reset
  // Hardware loads outrank a software write in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (cap_a_ev) begin
      cmp_cap_a_q <= cnt_q;
    end else if (ovf_ev) begin
      cmp_cap_a_q <= tcc_pkg::CAP_OVF_VALUE;
    end else if (wr_a) begin
      cmp_cap_a_q <= AVS_WRITEDATA[CNT_W-1:0];
    end
  end

  // Capture B register, no reset
  // Opposite edge and software capture share the load
  always_ff @(posedge CLK_SYS) begin
    if (cap_b_ev || software_capture_pulse) begin
      cap_b_q <= cnt_q;
    end
  end

  // ==========================================================================
  // Sticky status: hardware set wins over a write-one clear
  // Bit 0 flags a match, capture A or overflow event (not capture B), bit 1 an overflow
  always_comb begin
    irq_status_d = irq_status_q;
    if (wr_lane && sel_st) begin
      irq_status_d = irq_status_q & ~AVS_WRITEDATA[IRQ_W_L-1:0];
    end
    if (any_ev) begin
      irq_status_d[tcc_pkg::IRQ_EVENT_BIT] = 1'b1;
    end
    if (ovf_ev) begin
      irq_status_d[tcc_pkg::IRQ_OVF_BIT] = 1'b1;
    end
  end

  // Status register
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Level interrupt while any unmasked status bit is set
  // Masked bits keep their status for polling
  assign TIMER_INTERRUPT = |(irq_status_q & irq_mask_q);

endmodule
`default_nettype wire

// >>> tcc_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks for the timer/counter
module tcc_timer_chk (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [tcc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic TIMER_INPUT_PIN,
  input wire logic TIMER_INTERRUPT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  logic done;
  logic [7:0] idx;
  // Read completion and register index
  assign done = AVS_READ && !AVS_WAITREQUEST;
  assign idx = AVS_ADDRESS[9:2];
  // Read handshake steps
  sequence s_wait;
    AVS_READ && AVS_WAITREQUEST;
  endsequence
  sequence s_ans;
    AVS_READ && !AVS_WAITREQUEST;
  endsequence
  chk_read_one_wait: assert property (
      $rose(AVS_READ) |-> s_wait ##1 s_ans)
    else $error("read wait not one cycle");
  chk_write_no_wait: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  chk_ctrl_reads_zero: assert property (
      done && idx == tcc_pkg::IDX_CTRL |-> AVS_READDATA == 32'h0)
    else $error("control read not zero");
  chk_upper_zero: assert property (done |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_unmapped_zero: assert property (
      done && idx == 8'h00 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_edge_only_bit: assert property (
      done && idx == tcc_pkg::IDX_EXT_INT_CTRL
      |-> (AVS_READDATA[7:0] & 8'hF7) == 8'h00)
    else $error("edge register extra bits");
  chk_status_two_bits: assert property (
      done && idx == tcc_pkg::IDX_IRQ_STATUS |-> AVS_READDATA[7:2] == 6'h00)
    else $error("status extra bits");
  chk_mask_off_quiet: assert property (
      AVS_WRITE && AVS_BYTEENABLE[0] && idx == tcc_pkg::IDX_IRQ_MASK
      && AVS_WRITEDATA[1:0] == 2'h0 |=> ##1 !TIMER_INTERRUPT)
    else $error("interrupt despite mask");
  chk_irq_fall_write: assert property (
      $fell(TIMER_INTERRUPT) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
    else $error("interrupt dropped without write");
endmodule
`default_nettype wire

// >>> tcc_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pulse source on the timer input pin
module tcc_pulse_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic [15:0] high_len,
  input wire logic [15:0] low_len,
  output logic pin,
  output logic busy
);
  int n;
  // Idle low, no train running
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Train of pulses, every level held for its full length
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (n = 0; n < count; n++) begin
        pin <= 1'b1;
        repeat (high_len) @(posedge clk);
        pin <= 1'b0;
        repeat (low_len) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test_tcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the timer/counter
module test_tcc_timer;
  logic clk, rst_n, rd, wr, wait_req, pin, irq, go, busy;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [7:0] cnt, q;
  logic [15:0] hi, lo;
  longint t0, t1;
  int divs[3] = '{4096, 1024, 128};
  int miscompares = 0;
  int samples_checked = 0;
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); \
  end \
end
  tcc_timer u_tcc_timer (
    .CLK_SYS(clk), .RESETN(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .TIMER_INPUT_PIN(pin),
    .TIMER_INTERRUPT(irq)
  );
  tcc_pulse_src u_tcc_pulse_src (
    .clk(clk), .go(go), .count(cnt), .high_len(hi),
    .low_len(lo), .pin(pin), .busy(busy)
  );
  // Clock of 8 ns
  always #4 clk = ~clk;
  task summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'h0};
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    if (wait_req !== 1'b0) begin
      miscompares++;
      summarize;
    end
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, e, q)
  endtask
  task wait_irq(input int lim);
    int c;
    c = 0;
    while (irq !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
    if (c >= lim) begin
      `CHK("irq_wait", 1'b1, irq)
      summarize;
    end
  endtask
  task pulses(input logic [7:0] n, input logic [15:0] h,
    input logic [15:0] l);
    int c;
    c = 0;
    @(posedge clk);
    go <= 1'b1;
    cnt <= n;
    hi <= h;
    lo <= l;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(negedge clk);
      c++;
    end while (busy && c < 20000);
    if (busy !== 1'b0) begin
      miscompares++;
      summarize;
    end
  endtask
  task t_regs;
    rd_chk("ctrl", tcc_pkg::IDX_CTRL, 8'h00);
    rd_chk("unmapped", 8'h00, 8'h00);
    rd_chk("status", tcc_pkg::IDX_IRQ_STATUS, 8'h00);
    bus(1'b1, tcc_pkg::IDX_CTRL, 8'h40);
    rd_chk("soft_cap", tcc_pkg::IDX_CAP_B, 8'h00);
    bus(1'b1, tcc_pkg::IDX_CAP_B, 8'hAA);
    rd_chk("cap_b_ro", tcc_pkg::IDX_CAP_B, 8'h00);
    bus(1'b1, tcc_pkg::IDX_CMP_CAP_A, 8'h5A);
    @(posedge clk);
    be <= 4'h0;
    bus(1'b1, tcc_pkg::IDX_CMP_CAP_A, 8'hA5);
    @(posedge clk);
    be <= 4'hF;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("cmp_kept", tcc_pkg::IDX_CMP_CAP_A, 8'h5A);
    bus(1'b1, tcc_pkg::IDX_EXT_INT_CTRL, 8'hFF);
    rd_chk("edge_sel", tcc_pkg::IDX_EXT_INT_CTRL, 8'h08);
  endtask
  task t_timer;
    for (int s = 0; s < 3; s++) begin
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h00);
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'(s) << 2);
      bus(1'b1, tcc_pkg::IDX_CMP_CAP_A, 8'h02);
      bus(1'b1, tcc_pkg::IDX_IRQ_MASK, 8'h01);
      bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h03);
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h10 | (8'(s) << 2));
      wait_irq(20000);
      t0 = $time;
      bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h01);
      wait_irq(20000);
      t1 = $time;
      `CHK("period", longint'(2 * divs[s]), (t1 - t0) / 8)
    end
    bus(1'b1, tcc_pkg::IDX_CTRL, 8'h00);
    bus(1'b1, tcc_pkg::IDX_IRQ_MASK, 8'h00);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, tcc_pkg::IDX_IRQ_MASK, 8'h01);
    `CHK("irq_unmasked", 1'b1, irq)
    bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h01);
    `CHK("irq_cleared", 1'b0, irq)
  endtask
  task t_event;
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h00);
      bus(1'b1, tcc_pkg::IDX_EXT_INT_CTRL, e ? 8'h08 : 8'h00);
      bus(1'b1, tcc_pkg::IDX_CMP_CAP_A, 8'h04);
      bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h03);
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h0C);
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h1C);
      pulses(8'h03, 16'h0008, 16'h0008);
      bus(1'b1, tcc_pkg::IDX_CTRL, 8'h5C);
      rd_chk("ev_count", tcc_pkg::IDX_CAP_B, 8'h03);
      `CHK("ev_early", 1'b0, irq)
      pulses(8'h01, 16'h0008, 16'h0008);
      `CHK("ev_match", 1'b1, irq)
    end
  endtask
  task t_capture;
    bus(1'b1, tcc_pkg::IDX_CTRL, 8'h00);
    bus(1'b1, tcc_pkg::IDX_EXT_INT_CTRL, 8'h00);
    bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h03);
    bus(1'b1, tcc_pkg::IDX_CTRL, 8'h09);
    bus(1'b1, tcc_pkg::IDX_CTRL, 8'h19);
    fork
      pulses(8'h03, 16'd640, 16'd384);
      begin
        wait_irq(2000);
        bus(1'b0, tcc_pkg::IDX_CAP_B, 8'h00);
        bus(1'b0, tcc_pkg::IDX_CMP_CAP_A, 8'h00);
        bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h01);
        wait_irq(3000);
        bus(1'b1, tcc_pkg::IDX_IRQ_STATUS, 8'h01);
        bus(1'b0, tcc_pkg::IDX_CAP_B, 8'h00);
        `CHK("cap_width", 1'b1, q inside {8'h04, 8'h05})
      end
    join
    rd_chk("locked", tcc_pkg::IDX_IRQ_STATUS, 8'h00);
    bus(1'b0, tcc_pkg::IDX_CMP_CAP_A, 8'h00);
    `CHK("cap_period", 1'b1, q inside {8'h07, 8'h08})
    wait_irq(40000);
    rd_chk("ovf_stat", tcc_pkg::IDX_IRQ_STATUS, 8'h03);
    rd_chk("ovf_val", tcc_pkg::IDX_CMP_CAP_A, 8'hFF);
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 10'h000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'hF;
    go = 1'b0;
    cnt = 8'h00;
    hi = 16'h0008;
    lo = 16'h0008;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_timer;
    t_event;
    t_capture;
    summarize;
  end
endmodule
bind tcc_timer tcc_timer_chk u_tcc_timer_chk (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TIMER_INPUT_PIN(TIMER_INPUT_PIN), .TIMER_INTERRUPT(TIMER_INTERRUPT)
);
`default_nettype wire
